// File: design/rtsq_sequencer.sv
// Purpose: reset and start-up time-out sequencer with power status flags
// Assumes: i_reset is the power-on reset; pins are asynchronous to i_clk_sys
// Notes:   wake-up keeps core state, only a start-up count stalls the core
//
// Chosen here: the address map and the Wishbone slave port.
module rtsq_sequencer
	import rtsq_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_CYCLES    = POWERUP_DELAY_TIMER_CYCLES_DEF,
	parameter int BOR_MIN_CYCLES = BOR_MIN_CYCLES_DEF,
	parameter int OST_CYCLES     = OST_OSC_CYCLES
) (
	input  wire logic            i_clk_sys,         // system clock
	input  wire logic            i_reset,           // power-on reset
	input  wire logic            i_master_clear_n,  // master clear pin, async
	input  wire logic            i_brownout_below,  // supply below threshold, async
	input  wire logic            i_osc_input_pin,   // oscillator input, async
	input  wire logic            i_wdt_timeout,     // watchdog time-out pulse
	input  wire logic            i_sleep,           // core is asleep
	input  wire logic            i_wake_irq,        // interrupt wake request
	input  wire logic            i_global_irq_en,   // global interrupt enable
	input  wire logic [PC_W-1:0] i_pc_next,         // address after sleep
	input  wire logic            i_wb_cyc,          // wishbone cycle
	input  wire logic            i_wb_stb,          // wishbone strobe
	input  wire logic            i_wb_we,           // wishbone write
	input  wire logic [7:0]      i_wb_adr,          // wishbone byte address
	input  wire logic [31:0]     i_wb_dat,          // wishbone write data
	input  wire logic [3:0]      i_wb_sel,          // wishbone byte selects
	output logic      [31:0]     o_wb_dat,          // wishbone read data
	output logic                 o_wb_ack,          // wishbone acknowledge
	output logic                 o_core_reset,      // core held in reset
	output logic                 o_wake_stall,      // core stalled on wake count
	output logic                 o_pc_load,         // load program counter
	output logic      [PC_W-1:0] o_pc_value,        // program counter value
	output logic                 o_irq              // level interrupt
);

	localparam int POWERUP_DELAY_TIMER_W = $clog2(POWERUP_DELAY_TIMER_CYCLES + 1);
	localparam int BOR_W  = $clog2(BOR_MIN_CYCLES + 1);
	localparam int OST_W  = $clog2(OST_CYCLES + 1);
	localparam logic [POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST = POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
	localparam logic [BOR_W-1:0]  BOR_LAST  = BOR_W'(BOR_MIN_CYCLES - 1);
	localparam logic [OST_W-1:0]  OST_LAST  = OST_W'(OST_CYCLES - 1);

	if (POWERUP_DELAY_TIMER_CYCLES < 1 || BOR_MIN_CYCLES < 1 || OST_CYCLES < 1) begin : g_chk
		$error("rtsq_sequencer: counts must be at least one");
	end

	logic [2:0]          meta_q;
	logic [2:0]          sync_q;
	logic                osc_prev_q;
	logic                master_clear_pin_prev_q;
	logic                sleep_prev_q;
	rtsq_state_type      state_q;
	logic                wake_q;
	logic                seq_por_q;
	logic [POWERUP_DELAY_TIMER_W-1:0]   powerup_delay_timer_cnt_q;
	logic [OST_W-1:0]    ost_cnt_q;
	logic [BOR_W-1:0]    bor_cnt_q;
	logic [PC_W-1:0]     wake_vec_q;
	logic [3:0]          status_q;
	logic [3:0]          cfg_q;
	logic [IRQ_W-1:0]    irq_stat_q;
	logic [IRQ_W-1:0]    irq_mask_q;
	logic                ack_q;
	logic [31:0]         rdata_q;
	logic                core_reset_q;
	logic                pc_load_q;
	logic [PC_W-1:0]     pc_value_q;

	logic                master_clear_pin_low;
	logic                master_clear_pin_fall;
	logic                below;
	logic                bor_en;
	logic                crystal;
	logic                powerup_delay_timer_on;
	logic                osc_rise;
	logic                sleep_rise;
	logic                bor_trip;
	logic                powerup_delay_timer_done;
	logic                ost_done;
	logic                wdt_reset_evt;
	logic                wake_evt;
	logic                release_wake;
	logic                hold_d;
	logic [PC_W-1:0]     wake_vec_now;
	logic                wb_req;
	logic                wb_wr;
	logic [IRQ_W-1:0]    irq_evt;

	// two-stage synchronisers for the three pins
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			meta_q <= SYNC_RST;
			sync_q <= SYNC_RST;
		end else begin
			meta_q <= {i_osc_input_pin, i_brownout_below, i_master_clear_n};
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			osc_prev_q   <= 1'b0;
			master_clear_pin_prev_q  <= 1'b1;
			sleep_prev_q <= 1'b0;
		end else begin
			osc_prev_q   <= sync_q[2];
			master_clear_pin_prev_q  <= sync_q[0];
			sleep_prev_q <= i_sleep;
		end
	end

	assign master_clear_pin_low   = ~sync_q[0];
	assign master_clear_pin_fall  = master_clear_pin_prev_q & ~sync_q[0];
	assign below      = sync_q[1];
	assign osc_rise   = sync_q[2] & ~osc_prev_q;
	assign sleep_rise = i_sleep & ~sleep_prev_q;
	assign bor_en     = cfg_q[CFG_BOR_EN];
	assign crystal    = cfg_q[CFG_OSC_LSB +: 2] != OSC_RES_CAP;
	assign powerup_delay_timer_on    = ~cfg_q[CFG_POWERUP_DELAY_TIMER_DIS] | bor_en;

	// a short dip may slip through: only a full minimum duration trips
	assign bor_trip   = below & bor_en & (state_q != ST_BOR_HOLD)
		& (bor_cnt_q == BOR_LAST);
	assign powerup_delay_timer_done  = powerup_delay_timer_cnt_q == POWERUP_DELAY_TIMER_LAST;
	assign ost_done   = osc_rise & (ost_cnt_q == OST_LAST);
	assign wdt_reset_evt = i_wdt_timeout & ~i_sleep & (state_q == ST_RUN) & ~master_clear_pin_low;
	assign wake_evt   = i_sleep & (i_wdt_timeout | i_wake_irq) & (state_q == ST_RUN)
		& ~master_clear_pin_low;
	assign wake_vec_now = (~i_wdt_timeout & i_global_irq_en) ? PC_IRQ_VEC : i_pc_next;
	assign release_wake = (state_q == ST_OST & wake_q & ost_done & ~bor_trip)
		| (wake_evt & ~crystal & ~bor_trip);

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			bor_cnt_q <= '0;
		end else if (below & bor_en & (state_q != ST_BOR_HOLD) & ~bor_trip) begin
			bor_cnt_q <= bor_cnt_q + 1'b1;
		end else begin
			bor_cnt_q <= '0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state_q   <= ST_START;
			wake_q    <= 1'b0;
			seq_por_q <= 1'b1;
		end else if (bor_trip) begin
			state_q   <= ST_BOR_HOLD;
			wake_q    <= 1'b0;
			seq_por_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_START: begin
					if (powerup_delay_timer_on) begin
						state_q <= ST_POWERUP_DELAY_TIMER;
					end else if (crystal) begin
						state_q <= ST_OST;
					end else begin
						state_q <= ST_RUN;
					end
				end
				ST_POWERUP_DELAY_TIMER: begin
					if (below & bor_en) begin
						state_q <= ST_BOR_HOLD;
					end else if (powerup_delay_timer_done) begin
						// recovery after a brown-out trip skips the start-up count
						state_q <= (seq_por_q & crystal) ? ST_OST : ST_RUN;
					end
				end
				ST_OST: begin
					if (ost_done) begin
						state_q <= ST_RUN;
						wake_q  <= 1'b0;
					end
				end
				ST_BOR_HOLD: begin
					if (!below) begin
						state_q <= ST_POWERUP_DELAY_TIMER;
					end
				end
				ST_RUN: begin
					if (wake_evt & crystal) begin
						state_q <= ST_OST;
						wake_q  <= 1'b1;
					end
				end
				// unused codes restart the whole chain rather than hang
				default: begin
					state_q <= ST_START;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			powerup_delay_timer_cnt_q <= '0;
		end else if (state_q == ST_POWERUP_DELAY_TIMER && !powerup_delay_timer_done) begin
			powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + 1'b1;
		end else begin
			powerup_delay_timer_cnt_q <= '0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ost_cnt_q <= '0;
		end else if (state_q != ST_OST || ost_done) begin
			ost_cnt_q <= '0;
		end else if (osc_rise) begin
			ost_cnt_q <= ost_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			wake_vec_q <= PC_RESET_VEC;
		end else if (wake_evt) begin
			wake_vec_q <= wake_vec_now;
		end
	end

	// reset is held through every stage except a wake-up count
	assign hold_d = ((state_q != ST_RUN) & ~(state_q == ST_OST & wake_q))
		| master_clear_pin_low | wdt_reset_evt | bor_trip;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			core_reset_q <= 1'b1;
			pc_load_q    <= 1'b0;
			pc_value_q   <= PC_RESET_VEC;
		end else begin
			core_reset_q <= hold_d;
			pc_load_q    <= (core_reset_q & ~hold_d) | release_wake;
			if (core_reset_q & ~hold_d) begin
				pc_value_q <= PC_RESET_VEC;
			end else if (release_wake) begin
				pc_value_q <= wake_q ? wake_vec_q : wake_vec_now;
			end
		end
	end

	assign wb_req = i_wb_cyc & i_wb_stb;
	// a write lands on the edge where the master samples ack
	assign wb_wr  = wb_req & i_wb_we & ack_q & i_wb_sel[0];

	// flag updates; hardware events win over a software write
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			status_q <= STATUS_RST;
		end else begin
			if (wb_wr && i_wb_adr == REG_STATUS_OFS) begin
				status_q[BIT_BROWNOUT] <= i_wb_dat[BIT_BROWNOUT];
				status_q[BIT_POWERON]  <= i_wb_dat[BIT_POWERON];
			end
			if (bor_trip) begin
				// only meaningful while brown-out is enabled
				status_q[BIT_BROWNOUT]  <= 1'b0;
				status_q[BIT_TIMEOUT]   <= 1'b1;
				status_q[BIT_POWERDOWN] <= 1'b1;
			end else if (wdt_reset_evt) begin
				status_q[BIT_TIMEOUT]   <= 1'b0;
				status_q[BIT_POWERDOWN] <= 1'b1;
			end else if (wake_evt) begin
				status_q[BIT_TIMEOUT]   <= ~i_wdt_timeout;
				status_q[BIT_POWERDOWN] <= 1'b0;
			end else if ((master_clear_pin_fall & i_sleep) | sleep_rise) begin
				status_q[BIT_TIMEOUT]   <= 1'b1;
				status_q[BIT_POWERDOWN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			cfg_q <= CONFIG_RST;
		end else if (wb_wr && i_wb_adr == REG_CONFIG_OFS) begin
			cfg_q <= i_wb_dat[3:0];
		end
	end

	assign irq_evt[IRQ_POR]  = state_q == ST_START;
	assign irq_evt[IRQ_BOR]  = bor_trip;
	assign irq_evt[IRQ_WDT]  = wdt_reset_evt;
	assign irq_evt[IRQ_MASTER_CLEAR_PIN] = master_clear_pin_fall;
	assign irq_evt[IRQ_WAKE] = wake_evt;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			irq_stat_q <= IRQ_RST;
			irq_mask_q <= IRQ_RST;
		end else begin
			if (wb_wr && i_wb_adr == REG_IRQ_STAT_OFS) begin
				irq_stat_q <= (irq_stat_q & ~i_wb_dat[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_q <= irq_stat_q | irq_evt;
			end
			if (wb_wr && i_wb_adr == REG_IRQ_MASK_OFS) begin
				irq_mask_q <= i_wb_dat[IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= wb_req & ~ack_q;
			unique case (i_wb_adr)
				REG_STATUS_OFS:   rdata_q <= {28'h0000000, status_q};
				REG_CONFIG_OFS:   rdata_q <= {28'h0000000, cfg_q};
				REG_IRQ_STAT_OFS: rdata_q <= {27'h0000000, irq_stat_q};
				REG_IRQ_MASK_OFS: rdata_q <= {27'h0000000, irq_mask_q};
				default:          rdata_q <= 32'h00000000;
			endcase
		end
	end

	assign o_wb_ack     = ack_q;
	assign o_wb_dat     = rdata_q;
	assign o_core_reset = core_reset_q;
	assign o_wake_stall = (state_q == ST_OST) & wake_q;
	assign o_pc_load    = pc_load_q;
	assign o_pc_value   = pc_value_q;
	assign o_irq        = |(irq_stat_q & irq_mask_q);

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	sequence s_ost_exit;
		state_q == ST_OST ##1 state_q == ST_RUN;
	endsequence

	sequence s_powerup_delay_timer_exit;
		state_q == ST_POWERUP_DELAY_TIMER ##1 state_q != ST_POWERUP_DELAY_TIMER;
	endsequence

	ost_length_a: assert property (s_ost_exit |-> $past(ost_done))
		else $error("start-up count ended early");
	rc_no_count_a: assert property ((state_q != ST_OST && !crystal) |=> state_q != ST_OST)
		else $error("start-up count in resistor-capacitor mode");
	bor_disabled_a: assert property (!bor_en |-> !bor_trip)
		else $error("brown-out reset while disabled");
	bor_duration_a: assert property (bor_trip |-> below && $past(below) && $past(bor_en))
		else $error("brown-out trip without sustained low supply");
	bor_hold_a: assert property ((state_q == ST_BOR_HOLD && below) |=> core_reset_q)
		else $error("reset released during brown-out");
	powerup_delay_timer_restart_a: assert property ((state_q == ST_POWERUP_DELAY_TIMER && below && bor_en) |=>
		state_q == ST_BOR_HOLD ##1 powerup_delay_timer_cnt_q == '0)
		else $error("power-up delay not restarted");
	powerup_delay_timer_forced_a: assert property (((state_q == ST_START && bor_en)
		|| (state_q == ST_BOR_HOLD && !below)) |=> state_q == ST_POWERUP_DELAY_TIMER)
		else $error("power-up delay skipped with brown-out enabled");
	powerup_delay_timer_full_a: assert property (s_powerup_delay_timer_exit |-> $past(powerup_delay_timer_done) || state_q == ST_BOR_HOLD)
		else $error("power-up delay ended early");
	master_clear_pin_release_a: assert property ((core_reset_q && !hold_d) |=>
		(!core_reset_q && pc_load_q && pc_value_q == PC_RESET_VEC))
		else $error("release did not load reset vector");
	bor_flags_a: assert property (bor_trip |=> !status_q[BIT_BROWNOUT]
		&& status_q[BIT_TIMEOUT] && status_q[BIT_POWERDOWN])
		else $error("brown-out flags wrong");
	wake_keep_a: assert property ((wake_evt && crystal && !bor_trip) |=>
		o_wake_stall && !core_reset_q)
		else $error("wake-up treated as reset");

endmodule : rtsq_sequencer

// File: inc/rtsq_pkg.sv
// Purpose: constants and types of the reset and time-out sequencer
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes:   times are kept in their own unit, system-clock cycle counts derive from them
package rtsq_pkg;

	localparam int CLK_MHZ            = 125;
	// power-up delay, nominal
	localparam int POWERUP_DELAY_TIMER_TIME_US       = 72000;
	localparam int POWERUP_DELAY_TIMER_CYCLES_DEF    = POWERUP_DELAY_TIMER_TIME_US * CLK_MHZ;
	// least under-threshold time that must reset
	localparam int BOR_MIN_TIME_US    = 100;
	localparam int BOR_MIN_CYCLES_DEF = BOR_MIN_TIME_US * CLK_MHZ;
	localparam int OST_OSC_CYCLES     = 1024;

	// register byte offsets
	localparam logic [7:0] REG_STATUS_OFS   = 8'h00;
	localparam logic [7:0] REG_CONFIG_OFS   = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h0C;

	// power_reset_status fields
	localparam int BIT_BROWNOUT  = 0;
	localparam int BIT_POWERON   = 1;
	localparam int BIT_TIMEOUT   = 2;
	localparam int BIT_POWERDOWN = 3;
	localparam logic [3:0] STATUS_RST = 4'hC;

	// configuration fields
	localparam int CFG_OSC_LSB  = 0;
	localparam int CFG_POWERUP_DELAY_TIMER_DIS = 2;
	localparam int CFG_BOR_EN   = 3;
	localparam logic [3:0] CONFIG_RST = 4'h9;

	// interrupt event bits
	localparam int IRQ_POR  = 0;
	localparam int IRQ_BOR  = 1;
	localparam int IRQ_WDT  = 2;
	localparam int IRQ_MASTER_CLEAR_PIN = 3;
	localparam int IRQ_WAKE = 4;
	localparam int IRQ_W    = 5;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

	localparam int PC_W = 13;
	localparam logic [PC_W-1:0] PC_RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] PC_IRQ_VEC   = 13'h0004;

	// synchroniser reset: master clear idles high
	localparam logic [2:0] SYNC_RST = 3'h1;

	typedef enum logic [1:0] {
		OSC_CRYSTAL_LOW  = 2'b00,
		OSC_CRYSTAL_MID  = 2'b01,
		OSC_CRYSTAL_HIGH = 2'b10,
		OSC_RES_CAP      = 2'b11
	} rtsq_osc_type;

	typedef enum logic [2:0] {
		ST_START    = 3'b000,
		ST_POWERUP_DELAY_TIMER     = 3'b001,
		ST_OST      = 3'b010,
		ST_BOR_HOLD = 3'b011,
		ST_RUN      = 3'b100
	} rtsq_state_type;

endpackage : rtsq_pkg

// File: tb/tb_reset_timeout_sequencer.sv
// Purpose: self-checking bench of the reset and time-out sequencer
// Assumes: shortened delay counts, oscillator input toggling every four clocks
// Notes:   random dip lengths, wake addresses; fixed seed keeps runs repeatable
module tb_reset_timeout_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import rtsq_pkg::*;

	localparam int P_POWERUP_DELAY_TIMER  = 20;
	localparam int P_BOR   = 5;
	localparam int P_OST   = 8;
	localparam int OSC_PER = 8;

	logic            i_clk_sys        = 1'b0;
	logic            i_reset          = 1'b1;
	logic            i_master_clear_n = 1'b1;
	logic            i_brownout_below = 1'b0;
	logic            i_osc_input_pin  = 1'b0;
	logic            i_wdt_timeout    = 1'b0;
	logic            i_sleep          = 1'b0;
	logic            i_wake_irq       = 1'b0;
	logic            i_global_irq_en  = 1'b0;
	logic [PC_W-1:0] i_pc_next        = '0;
	logic            i_wb_cyc         = 1'b0;
	logic            i_wb_stb         = 1'b0;
	logic            i_wb_we          = 1'b0;
	logic [7:0]      i_wb_adr         = 8'h00;
	logic [31:0]     i_wb_dat         = 32'h0;
	logic [3:0]      i_wb_sel         = 4'hF;
	logic [31:0]     o_wb_dat;
	logic            o_wb_ack;
	logic            o_core_reset;
	logic            o_wake_stall;
	logic            o_pc_load;
	logic [PC_W-1:0] o_pc_value;
	logic            o_irq;
	logic [1:0]      osc_cnt          = 2'h0;
	logic [31:0]     rd;
	int              n;
	int              n_mismatch       = 0;
	int              n_checks         = 0;

	rtsq_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(P_POWERUP_DELAY_TIMER), .BOR_MIN_CYCLES(P_BOR), .OST_CYCLES(P_OST)) i_dut (
		.i_clk_sys, .i_reset, .i_master_clear_n, .i_brownout_below, .i_osc_input_pin,
		.i_wdt_timeout, .i_sleep, .i_wake_irq, .i_global_irq_en, .i_pc_next,
		.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel,
		.o_wb_dat, .o_wb_ack, .o_core_reset, .o_wake_stall, .o_pc_load, .o_pc_value, .o_irq
	);

	always #4 i_clk_sys = ~i_clk_sys;

	// slow oscillator so every rise survives the synchroniser
	always @(posedge i_clk_sys) begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3) begin
			i_osc_input_pin <= ~i_osc_input_pin;
		end
	end

	function automatic logic [PC_W-1:0] wake_vec(input logic by_irq, input logic global_irq_enable,
			input logic [PC_W-1:0] nxt);
		return (by_irq && global_irq_enable) ? 13'h0004 : nxt;
	endfunction : wake_vec

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic hang();
		n_mismatch++;
		$display("mismatch at %0t: wait ran out, seen %h expected %h", $time, 0, 1);
		results();
	endtask : hang

	// holds the request until the ack edge, then releases
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		@(posedge i_clk_sys);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= we;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		k = 0;
		do begin
			@(posedge i_clk_sys);
			k++;
		end while (o_wb_ack !== 1'b1 && k < 50);
		if (k >= 50) hang();
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		// a write lands on the ack edge; let it settle before outputs are looked at
		@(posedge i_clk_sys);
	endtask : wb

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
		wb(1'b0, adr, 32'h0);
		chk(rd & m, exp & m);
	endtask : rdchk

	task automatic wait_load(output int cyc);
		cyc = 0;
		do begin
			@(posedge i_clk_sys);
			cyc++;
		end while (o_pc_load !== 1'b1 && cyc < 3000);
		if (cyc >= 3000) hang();
	endtask : wait_load

	task automatic dip(input int len);
		@(posedge i_clk_sys);
		i_brownout_below <= 1'b1;
		repeat (len) @(posedge i_clk_sys);
		i_brownout_below <= 1'b0;
	endtask : dip

	initial begin
		void'($urandom(32'hB77B));
		repeat (4) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		wait_load(n);
		chk(n >= P_POWERUP_DELAY_TIMER + (P_OST - 1) * OSC_PER, 1'b1);
		chk(o_pc_value, 13'h0000);
		chk(o_core_reset, 1'b0);
		rdchk(REG_STATUS_OFS, 32'h0C, 32'hE);
		rdchk(REG_CONFIG_OFS, 32'h09, 32'hFFFFFFFF);
		rdchk(8'h10, 32'h0, 32'hFFFFFFFF);
		rdchk(REG_IRQ_STAT_OFS, 32'h01, 32'hFFFFFFFF);
		chk(o_irq, 1'b0);
		wb(1'b1, REG_IRQ_MASK_OFS, 32'h03);
		chk(o_irq, 1'b1);
		wb(1'b1, REG_IRQ_STAT_OFS, 32'h01);
		chk(o_irq, 1'b0);
		wb(1'b1, REG_STATUS_OFS, 32'h03);
		rdchk(REG_STATUS_OFS, 32'h0F, 32'hFFFFFFFF);
		for (int i = 0; i < 4; i++) begin
			dip(1 + ($urandom % 3));
			repeat (10) @(posedge i_clk_sys);
			chk(o_core_reset, 1'b0);
		end
		dip(P_BOR + 10);
		chk(o_core_reset, 1'b1);
		repeat (10) @(posedge i_clk_sys);
		chk(o_core_reset, 1'b1);
		dip(8);
		wait_load(n);
		chk(n >= P_POWERUP_DELAY_TIMER && n < P_POWERUP_DELAY_TIMER + 20, 1'b1);
		rdchk(REG_STATUS_OFS, 32'h0E, 32'hFFFFFFFF);
		chk(o_irq, 1'b1);
		wb(1'b1, REG_IRQ_STAT_OFS, 32'h02);
		chk(o_irq, 1'b0);
		wb(1'b1, REG_CONFIG_OFS, 32'h0D);
		dip(P_BOR + 4);
		wait_load(n);
		chk(n >= P_POWERUP_DELAY_TIMER, 1'b1);
		wb(1'b1, REG_CONFIG_OFS, 32'h05);
		dip(P_BOR + 20);
		repeat (4) @(posedge i_clk_sys);
		chk(o_core_reset, 1'b0);
		wb(1'b1, REG_STATUS_OFS, 32'h03);
		@(posedge i_clk_sys);
		i_wdt_timeout <= 1'b1;
		@(posedge i_clk_sys);
		i_wdt_timeout <= 1'b0;
		wait_load(n);
		chk(o_pc_value, 13'h0000);
		rdchk(REG_STATUS_OFS, 32'h0B, 32'hE);
		i_master_clear_n <= 1'b0;
		repeat (100) @(posedge i_clk_sys);
		chk(o_core_reset, 1'b1);
		i_master_clear_n <= 1'b1;
		wait_load(n);
		chk(n <= 6, 1'b1);
		chk(o_pc_value, 13'h0000);
		rdchk(REG_STATUS_OFS, 32'h0B, 32'hE);
		// bit 0 masked: flag is meaningless with brown-out off
		for (int i = 0; i < 8; i++) begin
			// low and high crystal and resistor-capacitor modes here, mid crystal ran at power-up
			wb(1'b1, REG_CONFIG_OFS, i[1] ? 32'h07 : (i[2] ? 32'h06 : 32'h04));
			i_pc_next       <= PC_W'($urandom);
			i_global_irq_en <= i[2];
			i_sleep         <= 1'b1;
			repeat (2) @(posedge i_clk_sys);
			if (i[0]) begin
				i_wake_irq <= 1'b1;
			end else begin
				i_wdt_timeout <= 1'b1;
			end
			@(posedge i_clk_sys);
			i_wake_irq    <= 1'b0;
			i_wdt_timeout <= 1'b0;
			if (!i[1]) begin
				repeat (6) @(posedge i_clk_sys);
				chk(o_wake_stall, 1'b1);
			end
			wait_load(n);
			chk(i[1] ? (n <= 3) : (n >= (P_OST - 1) * OSC_PER - 6), 1'b1);
			chk(o_pc_value, wake_vec(i[0], i[2], i_pc_next));
			chk(o_core_reset, 1'b0);
			i_sleep <= 1'b0;
			rdchk(REG_STATUS_OFS, i[0] ? 32'h07 : 32'h03, 32'hE);
		end
		results();
	end

endmodule : tb_reset_timeout_sequencer
